// >>> rio_pkg.sv
`default_nettype none
package rio_pkg;
	// Word areas of the host's core I/O word memory.
	localparam logic [15:0] RIO_RACK_BASE = 16'd3000;
	localparam logic [15:0] RIO_RACK_LAST = 16'd3049;
	localparam logic [15:0] RIO_RACK_WORDS = 16'd10;
	localparam logic [15:0] RIO_LARGE_WORDS = 16'd20;
	localparam logic [2:0] RIO_RACK_MAX = 3'd4;
	localparam logic [2:0] RIO_LARGE_MAX = 3'd3;
	localparam int RIO_RACKS = 5;
	localparam logic [15:0] RIO_UNIT_BASE = 16'd3100;
	localparam logic [15:0] RIO_UNIT_LAST = 16'd3131;
	localparam logic [5:0] RIO_UNIT_MAX = 6'd31;
	// Register byte offsets on the bus.
	localparam logic [7:0] RIO_OFS_SUMMARY = 8'h00;
	localparam logic [7:0] RIO_OFS_MASTER = 8'h04;
	localparam logic [7:0] RIO_OFS_LOCATION = 8'h08;
	localparam logic [7:0] RIO_OFS_REFRESH = 8'h0c;
	localparam logic [7:0] RIO_OFS_CONTROL = 8'h10;
	// Field positions and fixed codes.
	localparam int RIO_BIT_BUSERR = 5;
	localparam int RIO_BIT_REFRESH = 0;
	localparam int RIO_LOC_SLAVE_LO = 4;
	localparam int RIO_LOC_BYTE_LO = 8;
	localparam int RIO_CTL_HALT_LO = 0;
	localparam int RIO_CTL_CLEAR_LO = 2;
	localparam int RIO_CTL_LARGE_LO = 8;
	localparam logic [7:0] RIO_MASTER0_CODE = 8'hb0;
	localparam logic [15:0] RIO_CTL_RESET = 16'h0000;
	localparam logic [1:0] RIO_HTRANS_NONSEQ = 2'b10;

	typedef enum logic [1:0] {
		RIO_RF_IDLE = 2'b01,
		RIO_RF_LOAD = 2'b10
	} rio_refresh_e;

	// Request to place a slave's word in the I/O memory.
	typedef struct packed {
		logic valid;
		logic isUnit;
		logic isOptical;
		logic master;
		logic [2:0] rackNum;
		logic [4:0] slotNum;
		logic [4:0] unitNum;
		logic highHalf;
	} rio_map_req_s;

	typedef struct packed {
		logic valid;
		logic [15:0] word;
	} rio_map_rsp_s;

	// Transmission error seen on the remote bus.
	typedef struct packed {
		logic valid;
		logic master;
		logic isOptical;
		logic [4:0] slaveNum;
		logic highHalf;
	} rio_err_s;
endpackage : rio_pkg
`default_nettype wire

// >>> rio_word_map.sv
`timescale 1ns/1ps
`default_nettype none
module rio_word_map
	import rio_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire rio_pkg::rio_map_req_s mapReq,
	output rio_pkg::rio_map_rsp_s mapRsp,
	input wire rio_pkg::rio_err_s errIn,
	output logic [1:0] masterRun,
	output logic [4:0] rackOutClear
);
	import rio_pkg::*;

	function automatic logic [15:0] regSel(input logic [7:0] ofs, input logic [15:0] sumW,
		input logic [15:0] mstW, input logic [15:0] locW, input logic [15:0] refW,
		input logic [15:0] ctlW);
		case (ofs)
			RIO_OFS_SUMMARY: regSel = sumW;
			RIO_OFS_MASTER: regSel = mstW;
			RIO_OFS_LOCATION: regSel = locW;
			RIO_OFS_REFRESH: regSel = refW;
			RIO_OFS_CONTROL: regSel = ctlW;
			default: regSel = 16'h0000;
		endcase
	endfunction : regSel

	function automatic logic [15:0] locFromErr(input rio_err_s e);
		logic [15:0] w;
		w = 16'h0000;
		if (e.isOptical)
		begin
			w[RIO_LOC_SLAVE_LO] = e.highHalf;
			w[RIO_LOC_BYTE_LO +: 8] = {3'b000, e.slaveNum};
		end
		else
		begin
			w[RIO_LOC_SLAVE_LO +: 3] = e.slaveNum[2:0];
			w[RIO_LOC_BYTE_LO +: 8] = RIO_MASTER0_CODE | {7'h00, e.master};
		end
		locFromErr = w;
	endfunction : locFromErr

	logic busErr_r;
	logic [1:0] masterErr_r;
	logic [4:0] rackErr_r;
	logic [15:0] curLoc_r;
	logic [15:0] locWord_r;
	logic refreshReq_r;
	logic [15:0] control_r;
	rio_refresh_e refState_r;
	rio_refresh_e refState_nxt;
	logic wrPend_r;
	logic [7:0] wrAddr_r;
	logic [31:0] hrdata_r;
	rio_map_rsp_s mapRsp_r;
	logic [1:0] masterRun_r;
	logic [4:0] rackOutClear_r;
	logic hreadyout_r;
	logic hresp_r;

	// Bus decode. Only whole-word accesses are expected, so hsize is not checked.
	wire addrPhase = hsel && hready && (htrans == RIO_HTRANS_NONSEQ);
	wire wrStart = addrPhase && hwrite;
	wire refreshWrite = wrPend_r && (wrAddr_r == RIO_OFS_REFRESH) && hwdata[RIO_BIT_REFRESH];
	wire ctlWrite = wrPend_r && (wrAddr_r == RIO_OFS_CONTROL);
	wire refreshDone = (refState_r == RIO_RF_LOAD);
	wire [15:0] summaryWord = 16'(busErr_r) << RIO_BIT_BUSERR;
	wire [15:0] masterWord = {14'h0, masterErr_r};
	wire [15:0] refreshWord = 16'(refreshReq_r) << RIO_BIT_REFRESH;
	wire [15:0] readWord = regSel(haddr, summaryWord, masterWord, locWord_r, refreshWord,
		control_r);
	wire [1:0] haltSel = control_r[RIO_CTL_HALT_LO +: 2];
	wire [4:0] clearSel = control_r[RIO_CTL_CLEAR_LO +: 5];
	wire [3:0] largeSel = control_r[RIO_CTL_LARGE_LO +: 4];

	// Word mapping. The serving master never enters the address.
	wire rackIsLarge = (mapReq.rackNum <= RIO_LARGE_MAX) && largeSel[mapReq.rackNum[1:0]];
	wire largeNeighbour = (mapReq.rackNum != 3'd0) && (mapReq.rackNum <= RIO_LARGE_MAX)
		&& largeSel[2'(mapReq.rackNum - 3'd1)];
	wire [15:0] rackBlock = rackIsLarge ? RIO_LARGE_WORDS : RIO_RACK_WORDS;
	wire [15:0] rackWord = RIO_RACK_BASE + 16'(mapReq.rackNum) * RIO_RACK_WORDS
		+ 16'(mapReq.slotNum);
	wire rackOk = (mapReq.rackNum <= RIO_RACK_MAX) && (16'(mapReq.slotNum) < rackBlock)
		&& !(rackIsLarge && largeNeighbour) && (rackWord <= RIO_RACK_LAST);
	wire [5:0] unitIdx = 6'(mapReq.unitNum) + 6'(mapReq.isOptical && mapReq.highHalf);
	wire [15:0] unitWord = RIO_UNIT_BASE + 16'(unitIdx);
	wire unitOk = (unitIdx <= RIO_UNIT_MAX) && (unitWord <= RIO_UNIT_LAST);

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			mapRsp_r <= '0;
		end
		else
		begin
			mapRsp_r.valid <= mapReq.valid && (mapReq.isUnit ? unitOk : rackOk);
			mapRsp_r.word <= mapReq.isUnit ? unitWord : rackWord;
		end
	end

	// Bus slave: zero wait states, always OKAY, read data sampled at the address phase.
	// A read right behind a write to the same register still returns the old value.
	// Ready and response come from flops as well, so no output hangs on a gate.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			wrPend_r <= 1'b0;
			wrAddr_r <= 8'h00;
			hrdata_r <= 32'h0000_0000;
			hreadyout_r <= 1'b1;
			hresp_r <= 1'b0;
		end
		else
		begin
			hreadyout_r <= 1'b1;
			hresp_r <= 1'b0;
			wrPend_r <= wrStart;
			wrAddr_r <= wrStart ? haddr : wrAddr_r;
			hrdata_r <= (addrPhase && !hwrite) ? {16'h0000, readWord} : hrdata_r;
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			control_r <= RIO_CTL_RESET;
		end
		else if (ctlWrite)
		begin
			control_r <= hwdata[15:0];
		end
	end

	// Refresh sequence: request, one load cycle, then the request bit drops.
	always_comb
	begin
		case (refState_r)
			RIO_RF_IDLE: refState_nxt = refreshReq_r ? RIO_RF_LOAD : RIO_RF_IDLE;
			RIO_RF_LOAD: refState_nxt = RIO_RF_IDLE;
			default: refState_nxt = RIO_RF_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			refState_r <= RIO_RF_IDLE;
			refreshReq_r <= 1'b0;
			locWord_r <= 16'h0000;
		end
		else
		begin
			refState_r <= refState_nxt;
			refreshReq_r <= refreshWrite || (refreshReq_r && !refreshDone);
			locWord_r <= refreshDone ? curLoc_r : locWord_r;
		end
	end

	// Error capture. A new error in the clearing cycle wins over the clear.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			busErr_r <= 1'b0;
			masterErr_r <= 2'b00;
			curLoc_r <= 16'h0000;
		end
		else
		begin
			busErr_r <= errIn.valid || (busErr_r && !refreshDone);
			masterErr_r <= (refreshDone ? 2'b00 : masterErr_r)
				| ({1'b0, errIn.valid} << errIn.master);
			curLoc_r <= errIn.valid ? locFromErr(errIn) : curLoc_r;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < RIO_RACKS; gi++)
		begin : g_rack
			wire hit = errIn.valid && !errIn.isOptical && (errIn.slaveNum == 5'(gi));
			always_ff @(posedge clock or posedge rst)
			begin
				if (rst)
				begin
					rackErr_r[gi] <= 1'b0;
					rackOutClear_r[gi] <= 1'b0;
				end
				else
				begin
					rackErr_r[gi] <= hit || (rackErr_r[gi] && !refreshDone);
					rackOutClear_r[gi] <= clearSel[gi] && (hit || rackErr_r[gi]);
				end
			end
		end
		for (gi = 0; gi < 2; gi++)
		begin : g_master
			always_ff @(posedge clock or posedge rst)
			begin
				if (rst)
				begin
					masterRun_r[gi] <= 1'b1;
				end
				else
				begin
					masterRun_r[gi] <= !(haltSel[gi] && masterErr_r[gi]);
				end
			end
		end
	endgenerate

	assign hreadyout = hreadyout_r;
	assign hresp = hresp_r;
	assign hrdata = hrdata_r;
	assign mapRsp = mapRsp_r;
	assign masterRun = masterRun_r;
	assign rackOutClear = rackOutClear_r;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	property p_buserr_set;
		errIn.valid |=> busErr_r;
	endproperty
	a_buserr_set: assert property (p_buserr_set) else $error("bus error flag not set");

	property p_master_flag;
		errIn.valid |=> masterErr_r[$past(errIn.master)];
	endproperty
	a_master_flag: assert property (p_master_flag) else $error("master flag missing");

	property p_rack_code;
		errIn.valid && !errIn.isOptical |=>
			curLoc_r[15:8] == (RIO_MASTER0_CODE | {7'h00, $past(errIn.master)})
			&& curLoc_r[6:4] == $past(errIn.slaveNum[2:0]);
	endproperty
	a_rack_code: assert property (p_rack_code) else $error("rack location wrong");

	property p_opt_code;
		errIn.valid && errIn.isOptical |=>
			curLoc_r[15:8] == {3'b000, $past(errIn.slaveNum)} && curLoc_r[4] == $past(errIn.highHalf);
	endproperty
	a_opt_code: assert property (p_opt_code) else $error("optical location wrong");

	property p_refresh;
		$rose(refreshReq_r) |-> ##1 refreshDone ##1 (locWord_r == $past(curLoc_r) && !refreshReq_r);
	endproperty
	a_refresh: assert property (p_refresh) else $error("refresh did not complete");

	property p_loc_hold;
		!refreshDone |=> $stable(locWord_r);
	endproperty
	a_loc_hold: assert property (p_loc_hold) else $error("location word changed");

	property p_rack_range;
		mapRsp_r.valid && !$past(mapReq.isUnit) |->
			mapRsp_r.word >= RIO_RACK_BASE && mapRsp_r.word <= RIO_RACK_LAST;
	endproperty
	a_rack_range: assert property (p_rack_range) else $error("rack word out of area");

	property p_unit_word;
		mapReq.valid && mapReq.isUnit && !mapReq.isOptical |=>
			mapRsp_r.valid && mapRsp_r.word == RIO_UNIT_BASE + 16'($past(mapReq.unitNum));
	endproperty
	a_unit_word: assert property (p_unit_word) else $error("unit word wrong");

	property p_halt;
		errIn.valid && haltSel[errIn.master] && !ctlWrite |-> ##2 !masterRun_r[$past(errIn.master, 2)];
	endproperty
	a_halt: assert property (p_halt) else $error("master kept running");

	property p_refresh_clear;
		refreshDone && !errIn.valid |=>
			!busErr_r && masterErr_r == 2'b00;
	endproperty
	a_refresh_clear: assert property (p_refresh_clear) else $error("flags not cleared");

	property p_rack_clear;
		errIn.valid && !errIn.isOptical && errIn.slaveNum <= 5'(RIO_RACK_MAX)
			&& clearSel[errIn.slaveNum[2:0]] |=> rackOutClear_r[$past(errIn.slaveNum[2:0])];
	endproperty
	a_rack_clear: assert property (p_rack_clear) else $error("rack outputs not cleared");

	property p_large_map;
		mapReq.valid && !mapReq.isUnit && mapReq.rackNum == 3'd0 && largeSel[0]
			&& 16'(mapReq.slotNum) < RIO_LARGE_WORDS
			|=> mapRsp_r.valid && mapRsp_r.word == RIO_RACK_BASE + 16'($past(mapReq.slotNum));
	endproperty
	a_large_map: assert property (p_large_map) else $error("large rack word wrong");

	property p_empty_slot;
		mapReq.valid && !mapReq.isUnit && 16'(mapReq.slotNum) >= rackBlock |=> !mapRsp_r.valid;
	endproperty
	a_empty_slot: assert property (p_empty_slot) else $error("slot beyond rack accepted");

	property p_opt_word;
		mapReq.valid && mapReq.isUnit && mapReq.isOptical && mapReq.highHalf
			&& 6'(mapReq.unitNum) < RIO_UNIT_MAX
			|=> mapRsp_r.valid
			&& mapRsp_r.word == RIO_UNIT_BASE + 16'($past(mapReq.unitNum)) + 16'h0001;
	endproperty
	a_opt_word: assert property (p_opt_word) else $error("optical high word wrong");

	c_refresh: cover property (refreshWrite ##1 refreshReq_r ##2 !refreshReq_r);
	c_opt_err: cover property (errIn.valid && errIn.isOptical);
	c_large: cover property (mapRsp_r.valid && mapRsp_r.word > RIO_RACK_BASE + RIO_LARGE_WORDS);
	c_halt: cover property (masterRun_r != 2'b11);
	c_rack_clear: cover property (rackOutClear_r != 5'h00);
endmodule : rio_word_map
`default_nettype wire

// >>> rio_remote_model.sv
`timescale 1ns/1ps
`default_nettype none
module rio_remote_model
	import rio_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic fire,
	input wire rio_pkg::rio_err_s errCmd,
	output rio_pkg::rio_err_s errIn
);
	// Slaves are up and numbered before the host runs, so faults come as single pulses.
	// Rack and unit numbers never share a word, and only masters 0 and 1 exist.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			errIn <= '0;
		end
		else
		begin
			errIn <= fire ? errCmd : '0;
		end
	end
endmodule : rio_remote_model
`default_nettype wire

// >>> remote_io_word_map_and_error_status_test.sv
`timescale 1ns/1ps
`default_nettype none
module remote_io_word_map_and_error_status_test;
	import rio_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	rio_map_req_s mapReq = '0;
	rio_map_rsp_s mapRsp;
	rio_err_s errCmd = '0;
	rio_err_s errIn;
	logic fire = 1'b0;
	logic [1:0] masterRun;
	logic [4:0] rackOutClear;
	logic rdChk = 1'b0;
	logic mapChk = 1'b0;
	logic busChk = 1'b0;
	logic pinChk = 1'b0;
	logic [31:0] rdQ[$];
	logic [16:0] mapQ[$];
	logic [6:0] pinQ[$];
	int failures = 0;
	int cmp_count = 0;
	logic [31:0] seed = 32'd71518;
	always #20 clock = ~clock;
	rio_word_map dut (.clock(clock), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mapReq(mapReq),
		.mapRsp(mapRsp), .errIn(errIn), .masterRun(masterRun), .rackOutClear(rackOutClear));
	rio_remote_model far (.clock(clock), .rst(rst), .fire(fire), .errCmd(errCmd), .errIn(errIn));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	task automatic cmp(input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : cmp
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done
	// For a read, d is the expected data; it is checked by the watcher below.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		haddr <= a;
		htrans <= RIO_HTRANS_NONSEQ;
		hwrite <= wr;
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wr ? d : 32'h0;
		rdChk <= !wr;
		busChk <= 1'b1;
		if (!wr)
			rdQ.push_back(d);
		do @(posedge clock); while (hreadyout !== 1'b1);
		rdChk <= 1'b0;
		busChk <= 1'b0;
	endtask : bus
	task automatic mapTry(input rio_map_req_s r, input logic [16:0] exp);
		@(posedge clock);
		mapReq <= r;
		mapQ.push_back(exp);
		@(posedge clock);
		mapReq <= '0;
		mapChk <= 1'b1;
		@(posedge clock);
		mapChk <= 1'b0;
	endtask : mapTry
	task automatic raise(input rio_err_s e);
		@(posedge clock);
		errCmd <= e;
		fire <= 1'b1;
		@(posedge clock);
		fire <= 1'b0;
	endtask : raise
	// Note is {masterRun, rackOutClear}; both have settled two edges after the call.
	task automatic pinTry(input logic [6:0] exp);
		pinQ.push_back(exp);
		repeat (2) @(posedge clock);
		pinChk <= 1'b1;
		@(posedge clock);
		pinChk <= 1'b0;
	endtask : pinTry
	// The request bit drops two cycles after the write lands; the three-cycle wait lets it read back clear.
	task automatic refresh;
		bus(1'b1, RIO_OFS_REFRESH, 32'h1);
		repeat (3) @(posedge clock);
		bus(1'b0, RIO_OFS_REFRESH, 32'h0);
	endtask : refresh
	always @(posedge clock)
	begin
		if (rdChk)
			cmp(rdQ.pop_front(), hrdata);
		if (busChk)
			cmp(32'h0, 32'(hresp));
		if (pinChk)
		begin
			cmp(32'(pinQ[0][6:5]), 32'(masterRun));
			cmp(32'(pinQ[0][4:0]), 32'(rackOutClear));
			void'(pinQ.pop_front());
		end
		if (mapChk)
		begin
			if (mapQ[0][16])
				cmp(32'(mapQ[0]), 32'(mapRsp));
			else
				cmp(32'h0, 32'(mapRsp.valid));
			void'(mapQ.pop_front());
		end
	end
	initial
	begin
		#800000;
		failures++;
		test_done();
	end
	initial
	begin
		rio_map_req_s r;
		int k;
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		pinTry(7'h60);
		bus(1'b0, RIO_OFS_SUMMARY, 32'h0);
		bus(1'b0, RIO_OFS_MASTER, 32'h0);
		bus(1'b1, RIO_OFS_LOCATION, 32'hffff);
		bus(1'b0, RIO_OFS_LOCATION, 32'h0);
		bus(1'b0, 8'h14, 32'h0);
		$display("test registers done");
		for (k = 0; k < 82; k++)
		begin
			seed = lfsr(seed);
			r = '0;
			r.valid = 1'b1;
			r.master = seed[0];
			r.isUnit = (k >= 50);
			r.rackNum = 3'(k / 10);
			r.slotNum = 5'(k % 10);
			r.unitNum = 5'(k - 50);
			mapTry(r, {1'b1, (k < 50) ? RIO_RACK_BASE + 16'(k) : 16'(3050 + k)});
		end
		r = '0;
		r.valid = 1'b1;
		r.slotNum = 5'd10;
		mapTry(r, 17'h0);
		r.rackNum = 3'd5;
		r.slotNum = 5'd0;
		mapTry(r, 17'h0);
		r = '0;
		r.valid = 1'b1;
		r.isUnit = 1'b1;
		r.isOptical = 1'b1;
		r.highHalf = 1'b1;
		r.unitNum = 5'd5;
		mapTry(r, {1'b1, 16'd3106});
		r.unitNum = 5'd31;
		mapTry(r, 17'h0);
		bus(1'b1, RIO_OFS_CONTROL, 32'h0100);
		r = '0;
		r.valid = 1'b1;
		r.slotNum = 5'd15;
		mapTry(r, {1'b1, 16'd3015});
		bus(1'b1, RIO_OFS_CONTROL, 32'h0300);
		r.rackNum = 3'd1;
		r.slotNum = 5'd0;
		mapTry(r, 17'h0);
		$display("test mapping done");
		raise('{1'b1, 1'b1, 1'b0, 5'd3, 1'b0});
		bus(1'b0, RIO_OFS_SUMMARY, 32'h20);
		bus(1'b0, RIO_OFS_MASTER, 32'h2);
		bus(1'b0, RIO_OFS_LOCATION, 32'h0);
		refresh();
		bus(1'b0, RIO_OFS_LOCATION, 32'hb130);
		bus(1'b0, RIO_OFS_SUMMARY, 32'h0);
		raise('{1'b1, 1'b0, 1'b1, 5'h1a, 1'b1});
		bus(1'b0, RIO_OFS_MASTER, 32'h1);
		refresh();
		bus(1'b0, RIO_OFS_LOCATION, 32'h1a10);
		$display("test error flags done");
		bus(1'b1, RIO_OFS_CONTROL, 32'h0011);
		bus(1'b0, RIO_OFS_CONTROL, 32'h0011);
		raise('{1'b1, 1'b0, 1'b0, 5'd2, 1'b0});
		pinTry(7'h44);
		$display("test halt and clear done");
		test_done();
	end
endmodule : remote_io_word_map_and_error_status_test
`default_nettype wire
